// [rtl/wdt_tb_cfg.svh]
`ifndef WDT_TB_CFG_SVH
`define WDT_TB_CFG_SVH

// Register indices; the byte address is four times the index.
// The core and wake registers sit at the top of the 8-bit byte space.
`define IDX_RT_CLOCK_RATE_CONTROL 8'h09
`define IDX_INTERRUPT_CONTROL_FIRST 8'h0b
`define IDX_INTERRUPT_CONTROL_SECOND 8'h1e
`define IDX_STAT 8'h0a
`define IDX_CORE 8'h3e
`define IDX_WAKE 8'h3f

// First interrupt control register fields.
`define B_GIE 0
`define B_EEI 1
`define B_TBASE_INT_ENABLE 2
`define B_RTC_INT_ENABLE 3
`define B_EIF 4
`define B_TBF 5
`define B_RTF 6
// Second interrupt control register fields.
`define B_ETI 0
`define B_TF 4
// Status fields.
`define B_PDF 4
`define B_TO 5
// Core control register fields (write pulses; STK is a stored stack-full bit).
`define B_CLR1 0
`define B_CLRA 1
`define B_CLRB 2
`define B_HALT 3
`define B_STK 4

// Reset value and response codes.
`define RT_CLOCK_RATE_CONTROL_RST 8'h07
`define RESP_OK 2'b00
`define RESP_ERR 2'b10

// Vectors.
`define VEC_EXT 8'h04
`define VEC_TB 8'h08
`define VEC_RTC 8'h0c
`define VEC_TMR 8'h10

// Divider taps.
`define LCD_TAP 2
`define BUZ_BASE 1
`define QTR_TAP 0
`define RTC_BASE 7
`define TB_BASE 11
// Tap of period 2^14 under the two watchdog stages: 3*2^14..2^16 timeout.
`define WD_LOW 13

// Crystal and system clock rates in Hz.
`define XTAL_HZ 32768
`define SYS_HZ 100000000

`endif

// [rtl/wdt_tb_pkg.sv]
package wdt_tb_pkg;
  typedef enum logic [1:0] {
    RUN_ST,
    HALT_ST,
    WAKE_ST
  } run_state_t;
endpackage

// [rtl/wdt_timebase_rtc_halt_unit.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "wdt_tb_cfg.svh"
// Contract
// - Ext, RTC, timebase flags/enables at 0BH.
// - Counter flag and enable at 1EH.
// - Request flags stay set until serviced/cleared.
// - Halt stops system clock, quarter clock.
// - Watchdog on crystal; disabled means no-ops.
// - Watchdog counts in halt and wakes.
// - Normal overflow: chip reset, set timeout.
// - Halt overflow: warm reset, PC/SP only.
// - Reset pin, clear instruction, halt clear watchdog.
// - Option selects single or dual clear.
// - Timeout 2^15..2^16 (logic gives 3*2^14..2^16); clears hit last stages.
// - Seven-stage divider, eight-bit prescaler, LCD, buzzer.
// - Timebase sets bit 5 at selected period.
// - Timebase wakes halt unless flag preset.
// - RTC rate field selects 2^8..2^15.
// - RTC timeout sets bit 6, vector 0CH.
// - Halt keeps state, clears watchdog, flags.
// - Powerdown/timeout flag set and clear events.
// - Halt exits: reset, interrupt, port, watchdog.
// - Port/blocked wake resumes next instruction.
// - Preset flags cannot wake that halt.
// - Acknowledged wake delays service over one cycle.
// - Taking interrupt clears flag and global enable.
// - Priority ext, timebase, RTC, counter.
module wdt_timebase_rtc_halt_unit
  import wdt_tb_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter logic WD_ENABLE = 1'b1,
  parameter logic WD_DUAL = 1'b0,
  parameter logic [1:0] TB_SEL = 2'd3,
  parameter logic [2:0] BUZ_SEL = 3'd0,
  parameter logic [PORT_W-1:0] WAKE_MASK = '1,
  parameter int XTAL_DIV = `SYS_HZ / `XTAL_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_reset_pin_n,
  input wire logic ext_int_n,
  input wire logic counter_event,
  input wire logic [PORT_W-1:0] port_a,
  input wire logic int_ack,
  output logic int_req,
  output logic [7:0] int_vector,
  output logic sys_clk_en,
  output logic quarter_rate_clock,
  output logic halted,
  output logic chip_reset,
  output logic warm_reset,
  output logic resume_next,
  output logic lcd_clk,
  output logic buzzer_clk
);

  initial begin
    if (PORT_W < 1 || XTAL_DIV < 2 || XTAL_DIV > 65536) begin
      $error("unsupported parameter values");
    end
  end

  // ---------------------------------------------------------------
  // Crystal tick and divider chain.
  // ---------------------------------------------------------------
  localparam int DW = 15;
  logic [15:0] xdiv_q;
  logic xtick;
  logic [DW-1:0] chain_q;
  logic [DW-1:0] chain_d;
  logic [DW-1:0] rise;
  logic [1:0] wd_hi_q;
  run_state_t st_q;
  logic rst_all;
  logic wd_clr;

  assign xtick = (xdiv_q == 16'(XTAL_DIV - 1));
  assign chain_d = chain_q + 1'b1;
  assign rst_all = !ext_reset_pin_n;

  // The crystal never stops, so the chain runs in halt too.
  always_ff @(posedge aclk) begin
    if (!aresetn || xtick) begin
      xdiv_q <= '0;
    end else begin
      xdiv_q <= xdiv_q + 16'h0001;
    end
  end

  // Seven-stage divider plus eight-bit prescaler as one chain.
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_all) begin
      chain_q <= '0;
    end else if (xtick) begin
      chain_q <= chain_d;
    end
  end

  // Per-stage rising edge pulses, one per generate lane.
  genvar gi;
  generate
    for (gi = 0; gi < DW; gi++) begin : g_rise
      assign rise[gi] = xtick && (&chain_q[gi:0]);
    end
  endgenerate

  assign lcd_clk = chain_q[`LCD_TAP];
  assign buzzer_clk = chain_q[`BUZ_BASE + 32'(BUZ_SEL)];

  // ---------------------------------------------------------------
  // Watchdog: last two stages on top of the shared chain.
  // ---------------------------------------------------------------
  logic wd_ovf;
  logic clr_a_q;
  logic clr_b_q;
  logic core_wr;
  logic [7:0] core_bits;
  logic do_clr1;
  logic do_clra;
  logic do_clrb;
  logic do_halt;
  logic dual_done;

  assign do_clr1 = core_wr && core_bits[`B_CLR1] && WD_ENABLE && !WD_DUAL;
  assign do_clra = core_wr && core_bits[`B_CLRA] && WD_ENABLE && WD_DUAL;
  assign do_clrb = core_wr && core_bits[`B_CLRB] && WD_ENABLE && WD_DUAL;
  assign do_halt = core_wr && core_bits[`B_HALT] && st_q == RUN_ST;
  assign dual_done = (do_clra || clr_a_q) && (do_clrb || clr_b_q);
  assign wd_clr = do_clr1 || dual_done || do_halt || rst_all;
  assign wd_ovf = WD_ENABLE && rise[`WD_LOW] && (&wd_hi_q);

  // Clear instructions and halt reset only the final two watchdog stages; the reset pin also zeroes the chain.
  always_ff @(posedge aclk) begin
    if (!aresetn || wd_clr) begin
      wd_hi_q <= '0;
    end else if (rise[`WD_LOW]) begin
      wd_hi_q <= wd_hi_q + 2'b01;
    end
  end

  // Dual-mode half clears, remembered until the pair completes.
  always_ff @(posedge aclk) begin
    if (!aresetn || dual_done || rst_all) begin
      clr_a_q <= 1'b0;
      clr_b_q <= 1'b0;
    end else begin
      clr_a_q <= clr_a_q | do_clra;
      clr_b_q <= clr_b_q | do_clrb;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags and enables.
  // ---------------------------------------------------------------
  logic [7:0] rt_clock_rate_control_q;
  logic [7:0] ic0_q;
  logic [7:0] ic1_q;
  logic pdf_q;
  logic to_q;
  logic stk_full_q;
  logic [PORT_W-1:0] port_q;
  logic ext_q;
  logic ext_fall;
  logic tb_evt;
  logic rtc_evt;
  logic [3:0] pend;
  logic [3:0] take;
  logic [3:0] armed_q;
  logic w_ic0;
  logic w_ic1;
  logic w_rt_clock_rate_control;
  logic [7:0] wbyte;
  logic port_wake;
  logic irq_wake;
  logic int_ready;

  assign ext_fall = ext_q && !ext_int_n;
  assign tb_evt = rise[`TB_BASE + 32'(TB_SEL)];
  assign rtc_evt = rise[`RTC_BASE + 32'(rt_clock_rate_control_q[2:0])];
  assign pend = {ic1_q[`B_TF] & ic1_q[`B_ETI],
                 ic0_q[`B_RTF] & ic0_q[`B_RTC_INT_ENABLE],
                 ic0_q[`B_TBF] & ic0_q[`B_TBASE_INT_ENABLE],
                 ic0_q[`B_EIF] & ic0_q[`B_EEI]};
  // Fixed priority: lowest index wins.
  assign take = pend & ~(pend - 4'b0001);
  // Serviceable request, also judged while waking from halt.
  assign int_ready = ic0_q[`B_GIE] && |pend && !stk_full_q;
  assign int_req = int_ready && st_q == RUN_ST;
  assign int_vector = take[0] ? `VEC_EXT : take[1] ? `VEC_TB :
                      take[2] ? `VEC_RTC : `VEC_TMR;

  always_ff @(posedge aclk) begin
    ext_q <= ext_int_n;
    port_q <= port_a;
  end

  // Hardware set wins over software clear or acknowledge.
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_all) begin
      ic0_q <= '0;
      ic1_q <= '0;
      rt_clock_rate_control_q <= `RT_CLOCK_RATE_CONTROL_RST;
    end else begin
      if (w_ic0) begin
        ic0_q[6:0] <= wbyte[6:0];
      end
      if (w_ic1) begin
        ic1_q[`B_ETI] <= wbyte[`B_ETI];
        ic1_q[`B_TF] <= wbyte[`B_TF];
      end
      if (w_rt_clock_rate_control) begin
        rt_clock_rate_control_q <= {2'b00, wbyte[5:0]};
      end
      if (int_ack && int_req) begin
        ic0_q[`B_GIE] <= 1'b0;
        if (take[0]) ic0_q[`B_EIF] <= 1'b0;
        if (take[1]) ic0_q[`B_TBF] <= 1'b0;
        if (take[2]) ic0_q[`B_RTF] <= 1'b0;
        if (take[3]) ic1_q[`B_TF] <= 1'b0;
      end
      if (ext_fall) ic0_q[`B_EIF] <= 1'b1;
      if (tb_evt) ic0_q[`B_TBF] <= 1'b1;
      if (rtc_evt) ic0_q[`B_RTF] <= 1'b1;
      if (counter_event && st_q == RUN_ST) begin
        ic1_q[`B_TF] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Halt, wake and reset sequencing.
  // ---------------------------------------------------------------
  assign port_wake = |(port_q & ~port_a & WAKE_MASK);
  // Count signals are ignored in halt, so the counter cannot wake it.
  assign irq_wake = (ext_fall && armed_q[0]) || (tb_evt && armed_q[1])
                    || (rtc_evt && armed_q[2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= RUN_ST;
      armed_q <= '0;
      pdf_q <= 1'b0;
      to_q <= 1'b0;
      chip_reset <= 1'b0;
      warm_reset <= 1'b0;
      resume_next <= 1'b0;
      quarter_rate_clock <= 1'b0;
    end else begin
      chip_reset <= 1'b0;
      warm_reset <= 1'b0;
      resume_next <= 1'b0;
      if (st_q == RUN_ST && chain_q[`QTR_TAP] && xtick) begin
        quarter_rate_clock <= !quarter_rate_clock;
      end
      if (do_clr1) pdf_q <= 1'b0;
      case (st_q)
        RUN_ST: begin
          if (do_halt) begin
            st_q <= HALT_ST;
            pdf_q <= 1'b1;
            to_q <= 1'b0;
            armed_q <= ~{ic1_q[`B_TF], ic0_q[`B_RTF],
                         ic0_q[`B_TBF], ic0_q[`B_EIF]};
          end else if (wd_ovf) begin
            chip_reset <= 1'b1;
            to_q <= 1'b1;
          end
        end
        HALT_ST: begin
          if (rst_all) begin
            st_q <= RUN_ST;
          end else if (wd_ovf) begin
            warm_reset <= 1'b1;
            to_q <= 1'b1;
            st_q <= RUN_ST;
          end else if (port_wake || irq_wake) begin
            st_q <= WAKE_ST;
          end
        end
        WAKE_ST: begin
          // One extra cycle lets the block judge the request (int_ready) before it picks resume_next; int_req stays low until RUN_ST.
          resume_next <= !int_ready;
          st_q <= RUN_ST;
        end
        default: st_q <= RUN_ST;
      endcase
    end
  end

  assign halted = (st_q == HALT_ST);
  assign sys_clk_en = (st_q != HALT_ST);

  // ---------------------------------------------------------------
  // AXI4-Lite slave.
  // ---------------------------------------------------------------
  logic aw_q;
  logic w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic wr_go;
  logic wr_hit;
  logic [7:0] ra;
  logic rd_hit;
  logic [7:0] rbyte;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_q && w_q;
  assign wbyte = wd_q[7:0];
  assign w_ic0 = wr_go && ws_q[0] && awa_q == `IDX_INTERRUPT_CONTROL_FIRST;
  assign w_ic1 = wr_go && ws_q[0] && awa_q == `IDX_INTERRUPT_CONTROL_SECOND;
  assign w_rt_clock_rate_control = wr_go && ws_q[0] && awa_q == `IDX_RT_CLOCK_RATE_CONTROL;
  assign core_wr = wr_go && ws_q[0] && awa_q == `IDX_CORE;
  assign core_bits = wbyte;
  assign wr_hit = awa_q == `IDX_INTERRUPT_CONTROL_FIRST || awa_q == `IDX_INTERRUPT_CONTROL_SECOND
                  || awa_q == `IDX_RT_CLOCK_RATE_CONTROL || awa_q == `IDX_CORE;
  assign ra = s_axi_araddr[7:0] >> 2;
  assign rd_hit = ra == `IDX_INTERRUPT_CONTROL_FIRST || ra == `IDX_INTERRUPT_CONTROL_SECOND
                  || ra == `IDX_RT_CLOCK_RATE_CONTROL || ra == `IDX_STAT
                  || ra == `IDX_CORE || ra == `IDX_WAKE;
  assign rbyte = ra == `IDX_INTERRUPT_CONTROL_FIRST ? {1'b0, ic0_q[6:0]} :
                 ra == `IDX_INTERRUPT_CONTROL_SECOND ? ic1_q :
                 ra == `IDX_RT_CLOCK_RATE_CONTROL ? rt_clock_rate_control_q :
                 ra == `IDX_STAT ? {2'b00, to_q, pdf_q, 4'h0} :
                 ra == `IDX_CORE ? {3'b000, stk_full_q, 4'h0} :
                 ra == `IDX_WAKE ? {4'h0, armed_q} : 8'h00;

  // Write side: address and data latched in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OK;
      stk_full_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr >> 2;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OK : `RESP_ERR;
        if (core_wr) stk_full_q <= wbyte[`B_STK];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read side: one cycle from address to data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rbyte};
      s_axi_rresp <= rd_hit ? `RESP_OK : `RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  halt_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_halt |=> pdf_q && !to_q && halted && wd_hi_q == 2'b00)
    else $error("halt did not set flags");
  wd_warm_a: assert property (@(posedge aclk) disable iff (!aresetn)
    halted && wd_ovf && !rst_all |=> warm_reset && to_q && !chip_reset)
    else $error("halt overflow not warm");
  wd_chip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == RUN_ST && wd_ovf && !do_halt |=> chip_reset && to_q)
    else $error("overflow no chip reset");
  ack_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    int_ack && int_req && take[0] && !ext_fall && !rst_all
    |=> !ic0_q[`B_GIE] && !ic0_q[`B_EIF])
    else $error("ack did not clear");
  tb_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tb_evt && !rst_all |=> ic0_q[`B_TBF])
    else $error("timebase flag lost");
  rtc_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rtc_evt && !rst_all |=> ic0_q[`B_RTF])
    else $error("rtc flag lost");
  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ic0_q[`B_RTF] && !w_ic0 && !int_ack && !rst_all |=> ic0_q[`B_RTF])
    else $error("flag dropped");
  clk_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    halted |-> !sys_clk_en ##1 $stable(quarter_rate_clock))
    else $error("clock ran in halt");

endmodule

// [tb/core_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Processor core stand-in: takes interrupt requests.
// ----------------------------------------------------------------
module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic int_req,
  input wire logic [7:0] int_vector,
  input wire logic [3:0] ack_delay,
  output logic int_ack,
  output logic [7:0] taken_vec,
  output logic [7:0] taken_cnt
);
  logic [3:0] wait_q;

  // The core answers after ack_delay cycles with a one-cycle pulse.
  // It skips the cycle after its own pulse, because the request only
  // drops once the block has seen the acknowledge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_ack <= 1'b0;
      taken_vec <= 8'h00;
      taken_cnt <= 8'h00;
      wait_q <= 4'h0;
    end else begin
      int_ack <= 1'b0;
      if (int_req && !int_ack) begin
        if (wait_q >= ack_delay) begin
          int_ack <= 1'b1;
          taken_vec <= int_vector;
          taken_cnt <= taken_cnt + 8'h01;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule

// [tb/wdt_timebase_rtc_halt_unit_bench.sv]
`timescale 1ns/10ps
module wdt_timebase_rtc_halt_unit_bench;
  import wdt_tb_pkg::*;
  localparam int XDIV = 2;
  localparam logic [7:0] A_RT_CLOCK_RATE_CONTROL = 8'h24;
  localparam logic [7:0] A_ST = 8'h28;
  localparam logic [7:0] A_IC0 = 8'h2c;
  localparam logic [7:0] A_IC1 = 8'h78;
  // Core control index 0x3e times four.
  localparam logic [7:0] A_CORE = 8'hf8;
  localparam logic [7:0] A_BAD = 8'h50;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rst_pin_n, ext_int_n, cnt_ev;
  logic int_ack, int_req, sys_clk_en, qclk, halted, chip_rst, warm_rst;
  logic resume, lcd_clk, buz_clk;
  logic [7:0] awaddr, araddr, int_vector, taken_vec, taken_cnt, port_a;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, ack_delay;
  logic [1:0] bresp, rresp, last_b, last_r;
  int failures, total_checks, resume_cnt;

  // ----------------------------------------------------------------
  // Design, core stand-in and clock.
  // ----------------------------------------------------------------
  wdt_timebase_rtc_halt_unit #(.XTAL_DIV(XDIV), .TB_SEL(2'd0)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_reset_pin_n(rst_pin_n),
    .ext_int_n(ext_int_n), .counter_event(cnt_ev), .port_a(port_a),
    .int_ack(int_ack), .int_req(int_req), .int_vector(int_vector),
    .sys_clk_en(sys_clk_en), .quarter_rate_clock(qclk),
    .halted(halted), .chip_reset(chip_rst), .warm_reset(warm_rst),
    .resume_next(resume), .lcd_clk(lcd_clk), .buzzer_clk(buz_clk));
  core_model core (.aclk(aclk), .aresetn(aresetn), .int_req(int_req),
    .int_vector(int_vector), .ack_delay(ack_delay), .int_ack(int_ack),
    .taken_vec(taken_vec), .taken_cnt(taken_cnt));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Resume pulses last one cycle, so they are counted as they pass.
  always @(posedge aclk) begin
    if (resume === 1'b1) begin
      resume_cnt++;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready for responses is held high, so only the valids move.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok, w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok) && n < 50) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    last_b = bresp;
    if (n >= 50) failures++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    last_r = rresp;
    if (n >= 50) failures++;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & {24'h0, m}, {24'h0, e});
  endtask

  task automatic wake_by_port();
    int n;
    n = 0;
    port_a <= 8'hfe;
    while (halted !== 1'b0 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    port_a <= 8'hff;
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    rdc(A_RT_CLOCK_RATE_CONTROL, 8'hff, 8'h07);
    rdc(A_IC0, 8'hff, 8'h00);
    rdc(A_IC1, 8'hff, 8'h00);
    rdc(A_ST, 8'h30, 8'h00);
    rd(A_BAD, d);
    chk(32'(last_r), 32'(2'b10));
    wr(A_BAD, 8'h55);
    chk(32'(last_b), 32'(2'b10));
    wr(A_IC0, 8'h0f);
    rdc(A_IC0, 8'h8f, 8'h0f);
    wr(A_IC1, 8'h01);
    rdc(A_IC1, 8'hff, 8'h01);
    wr(A_IC1, 8'h00);
    $display("reset and register test done");
  endtask

  // Toggles over 32 cycles: LCD at crystal/8, buzzer and quarter at /4.
  task automatic t_clocks();
    logic l, b, q;
    int nl, nb, nq;
    nl = 0;
    nb = 0;
    nq = 0;
    l = lcd_clk;
    b = buz_clk;
    q = qclk;
    repeat (32) begin
      @(posedge aclk);
      if (lcd_clk !== l) nl++;
      if (buz_clk !== b) nb++;
      if (qclk !== q) nq++;
      l = lcd_clk;
      b = buz_clk;
      q = qclk;
    end
    chk(32'(nl), 32'(32 / (4 * XDIV)));
    chk(32'(nb), 32'(32 / (2 * XDIV)));
    chk(32'(nq), 32'(32 / (2 * XDIV)));
    $display("divider clock test done");
  endtask

  // A flag set while disabled waits; a full stack blocks it too.
  task automatic t_ext();
    logic [7:0] c0;
    wr(A_CORE, 8'h01);
    chk(32'(last_b), 32'(2'b00));
    wr(A_IC0, 8'h00);
    ext_int_n <= 1'b0;
    repeat (3) @(posedge aclk);
    ext_int_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(int_req), 32'd0);
    rdc(A_IC0, 8'h10, 8'h10);
    c0 = taken_cnt;
    wr(A_CORE, 8'h10);
    wr(A_IC0, 8'h13);
    repeat (3) @(posedge aclk);
    chk(32'(int_req), 32'd0);
    wr(A_CORE, 8'h00);
    repeat (20) @(posedge aclk);
    chk(32'(taken_cnt - c0), 32'd1);
    chk(32'(taken_vec), 32'h04);
    rdc(A_IC0, 8'h11, 8'h00);
    $display("external interrupt test done");
  endtask

  // Two pending sources with a slow core: the order is fixed.
  task automatic t_prio();
    ack_delay <= 4'd5;
    wr(A_IC0, 8'h00);
    wr(A_IC1, 8'h01);
    cnt_ev <= 1'b1;
    ext_int_n <= 1'b0;
    @(posedge aclk);
    cnt_ev <= 1'b0;
    repeat (2) @(posedge aclk);
    ext_int_n <= 1'b1;
    wr(A_IC0, 8'h13);
    repeat (20) @(posedge aclk);
    chk(32'(taken_vec), 32'h04);
    rdc(A_IC1, 8'h10, 8'h10);
    wr(A_IC0, 8'h01);
    repeat (20) @(posedge aclk);
    chk(32'(taken_vec), 32'h10);
    rdc(A_IC1, 8'h10, 8'h00);
    wr(A_IC1, 8'h00);
    $display("priority test done");
  endtask

  // Period between two real-time ticks for each of three codes.
  task automatic t_rtc();
    logic [31:0] d;
    longint t[2];
    int exp;
    for (int c = 0; c < 3; c++) begin
      wr(A_CORE, 8'h01);
      wr(A_RT_CLOCK_RATE_CONTROL, 8'(c));
      rdc(A_RT_CLOCK_RATE_CONTROL, 8'h07, 8'(c));
      for (int k = 0; k < 3; k++) begin
        wr(A_IC0, 8'h00);
        d = 32'h0;
        for (int n = 0; n < 3000 && d[6] !== 1'b1; n++) rd(A_IC0, d);
        if (k > 0) t[k-1] = $time / 10;
      end
      exp = (256 << c) * XDIV;
      chk(32'((t[1] - t[0] >= exp - 10) && (t[1] - t[0] <= exp + 10)),
          32'd1);
    end
    $display("real-time clock test done");
  endtask

  task automatic t_halt_port();
    logic q;
    int r0;
    wr(A_CORE, 8'h01);
    r0 = resume_cnt;
    wr(A_CORE, 8'h08);
    repeat (2) @(posedge aclk);
    chk(32'(halted), 32'd1);
    chk(32'(sys_clk_en), 32'd0);
    q = qclk;
    repeat (20) @(posedge aclk);
    chk(32'(qclk), 32'(q));
    rdc(A_ST, 8'h30, 8'h10);
    wake_by_port();
    repeat (4) @(posedge aclk);
    chk(32'(halted), 32'd0);
    chk(32'(resume_cnt - r0), 32'd1);
    wr(A_CORE, 8'h01);
    rdc(A_ST, 8'h30, 8'h00);
    $display("halt and port wake test done");
  endtask

  // Preset flags must not wake; a fresh time-base tick must.
  // A wake with the interrupt enabled must lead to an acknowledge.
  task automatic t_tbase();
    int n;
    int r0;
    logic [7:0] c0;
    wr(A_CORE, 8'h01);
    wr(A_RT_CLOCK_RATE_CONTROL, 8'h00);
    wr(A_IC0, 8'h00);
    repeat (4096 * XDIV + 50) @(posedge aclk);
    rdc(A_IC0, 8'h60, 8'h60);
    wr(A_CORE, 8'h08);
    repeat (4096 * XDIV + 200) @(posedge aclk);
    chk(32'(halted), 32'd1);
    wake_by_port();
    wr(A_IC0, 8'h40);
    r0 = resume_cnt;
    wr(A_CORE, 8'h08);
    n = 0;
    while (halted !== 1'b0 && n < 4096 * XDIV + 200) begin
      @(posedge aclk);
      n++;
    end
    repeat (4) @(posedge aclk);
    chk(32'(halted), 32'd0);
    chk(32'(resume_cnt - r0), 32'd1);
    rdc(A_IC0, 8'h20, 8'h20);
    r0 = resume_cnt;
    c0 = taken_cnt;
    wr(A_IC0, 8'h45);
    wr(A_CORE, 8'h08);
    n = 0;
    while (halted !== 1'b0 && n < 4096 * XDIV + 200) begin
      @(posedge aclk);
      n++;
    end
    repeat (20) @(posedge aclk);
    chk(32'(halted), 32'd0);
    chk(32'(resume_cnt - r0), 32'd0);
    chk(32'(taken_cnt - c0), 32'd1);
    chk(32'(taken_vec), 32'h08);
    $display("time base wake test done");
  endtask

  // The reset pin leaves halt and clears registers, not the status.
  task automatic t_pin();
    wr(A_RT_CLOCK_RATE_CONTROL, 8'h03);
    wr(A_IC0, 8'h0e);
    wr(A_CORE, 8'h08);
    rst_pin_n <= 1'b0;
    @(posedge aclk);
    rst_pin_n <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(32'(halted), 32'd0);
    rdc(A_RT_CLOCK_RATE_CONTROL, 8'hff, 8'h07);
    rdc(A_IC0, 8'hff, 8'h00);
    rdc(A_ST, 8'h30, 8'h10);
    $display("reset pin test done");
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard.
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, arvalid, cnt_ev} = 4'h0;
    {bready, rready, rst_pin_n, ext_int_n} = 4'hf;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    port_a = 8'hff;
    ack_delay = 4'd0;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_clocks();
    t_ext();
    t_prio();
    t_rtc();
    t_halt_port();
    t_tbase();
    t_pin();
    wrap_up();
  end

  // The scenarios need about 41k cycles; 100k cycles means a hang.
  initial begin
    #1_000_000;
    failures++;
    wrap_up();
  end
endmodule
